// ==== verilog/gxcd_device.sv ====
// guest exit control decode: control vectors and exit decision
// assumes the pipeline holds boundary inputs valid for one cycle each
`timescale 1ns/1ps
`include "gxcd_defs.svh"
module gxcd_device (
    // link to pipeline
    gxcd_if.device         lnk,
    // apb slave
    input  wire logic        pclk_en_unused,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);
    import gxcd_pkg::*;

    logic [31:0]  async_event_exit_controls_q;
    logic [31:0]  instruction_exit_controls_q;
    logic         entry_fail_q;
    logic [31:0]  exit_count_q;
    gxcd_cause_t  last_cause_q;
    logic         dec_valid_q;
    gxcd_action_t dec_action_q;
    gxcd_cause_t  dec_cause_q;
    logic         ext_masked_q;
    logic         nmi_blk_q;
    logic         vnmi_blk_q;
    logic         wr_acc;
    logic [31:0]  a_wr;
    logic [31:0]  i_wr;
    logic [1:0]   bad_q;

    function automatic logic [31:0] fix_vec(input logic [31:0] v,
                                            input logic [31:0] defd,
                                            input logic [31:0] one);
        fix_vec = (v & defd) | one;
    endfunction

    // storage forces reserved bits, so the raw write is judged
    function automatic logic bad_vec(input logic [31:0] v,
                                     input logic [31:0] defd,
                                     input logic [31:0] one);
        bad_vec = ((v & ~defd) != one);
    endfunction

    assign wr_acc  = psel & penable & pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign a_wr    = async_event_exit_controls_q;
    assign i_wr    = instruction_exit_controls_q;

    always_ff @(posedge lnk.core_clk or negedge lnk.reset_n) begin
        if (!lnk.reset_n) begin
            async_event_exit_controls_q <= `GXCD_ASYNC_RESET;
        end else if (wr_acc && paddr == `GXCD_OFF_ASYNC_CTL) begin
            async_event_exit_controls_q <= fix_vec(pwdata, `GXCD_ASYNC_DEFINED,
                                                   `GXCD_ASYNC_FIXED1);
        end
    end

    always_ff @(posedge lnk.core_clk or negedge lnk.reset_n) begin
        if (!lnk.reset_n) begin
            instruction_exit_controls_q <= `GXCD_INSN_RESET;
        end else if (wr_acc && paddr == `GXCD_OFF_INSN_CTL) begin
            instruction_exit_controls_q <= fix_vec(pwdata, `GXCD_INSN_DEFINED,
                                                   `GXCD_INSN_FIXED1);
        end
    end

    // a write re-judges entry against the other vector as it stands
    always_ff @(posedge lnk.core_clk or negedge lnk.reset_n) begin
        if (!lnk.reset_n) begin
            entry_fail_q <= 1'b0;
            bad_q        <= 2'b00;
        end else if (wr_acc && paddr == `GXCD_OFF_ASYNC_CTL) begin
            bad_q[0]     <= bad_vec(pwdata, `GXCD_ASYNC_DEFINED, `GXCD_ASYNC_FIXED1);
            entry_fail_q <= bad_vec(pwdata, `GXCD_ASYNC_DEFINED, `GXCD_ASYNC_FIXED1) | bad_q[1]
                          | (pwdata[`GXCD_ASYNC_VIRT_NMI]
                             & ~pwdata[`GXCD_ASYNC_NMI_EXIT])
                          | (i_wr[`GXCD_INSN_NMI_WINDOW] & ~pwdata[`GXCD_ASYNC_VIRT_NMI]);
        end else if (wr_acc && paddr == `GXCD_OFF_INSN_CTL) begin
            bad_q[1]     <= bad_vec(pwdata, `GXCD_INSN_DEFINED, `GXCD_INSN_FIXED1);
            entry_fail_q <= bad_vec(pwdata, `GXCD_INSN_DEFINED, `GXCD_INSN_FIXED1) | bad_q[0]
                          | (a_wr[`GXCD_ASYNC_VIRT_NMI] & ~a_wr[`GXCD_ASYNC_NMI_EXIT])
                          | (pwdata[`GXCD_INSN_NMI_WINDOW]
                             & ~a_wr[`GXCD_ASYNC_VIRT_NMI]);
        end
    end

    // apb read mux
    always_comb begin
        case (paddr)
            `GXCD_OFF_ASYNC_CTL: prdata = async_event_exit_controls_q;
            `GXCD_OFF_INSN_CTL:  prdata = instruction_exit_controls_q;
            `GXCD_OFF_ASYNC_CAP: prdata = `GXCD_ASYNC_FIXED1;
            `GXCD_OFF_INSN_CAP:  prdata = `GXCD_INSN_FIXED1;
            `GXCD_OFF_STATUS:    prdata = {27'h0, entry_fail_q, last_cause_q};
            `GXCD_OFF_GUEST:     prdata = exit_count_q;
            default:             prdata = 32'h0000_0000;
        endcase
    end

    // exit decision, in priority order: async events, windows, instruction
    logic         a_ext, a_nmi, a_vnmi;
    logic         ext_blocked, nmi_blk, vnmi_blk;
    gxcd_action_t act;
    gxcd_cause_t  cause;

    always_comb begin
        a_ext    = async_event_exit_controls_q[`GXCD_ASYNC_EXT_INT_EXIT];
        a_nmi    = async_event_exit_controls_q[`GXCD_ASYNC_NMI_EXIT];
        a_vnmi   = async_event_exit_controls_q[`GXCD_ASYNC_VIRT_NMI];
        // exiting mode ignores interrupt_flag for blocking
        ext_blocked = lnk.other_int_block | (~a_ext & ~lnk.interrupt_flag);
        nmi_blk  = a_vnmi ? 1'b0 : lnk.nmi_block_flag;
        vnmi_blk = a_vnmi & lnk.nmi_block_flag;
        act      = GXCD_ACT_NORMAL;
        cause    = GXCD_CAUSE_NONE;
        if (lnk.nmi_pending && !nmi_blk) begin
            act   = a_nmi ? GXCD_ACT_EXIT : GXCD_ACT_IDT_NMI;
            cause = a_nmi ? GXCD_CAUSE_NMI : GXCD_CAUSE_NONE;
        end else if (lnk.ext_int_pending && !ext_blocked) begin
            act   = a_ext ? GXCD_ACT_EXIT : GXCD_ACT_IDT_INT;
            cause = a_ext ? GXCD_CAUSE_EXT_INT : GXCD_CAUSE_NONE;
        end else if (i_wr[`GXCD_INSN_INT_WINDOW] && lnk.interrupt_flag
                     && !lnk.other_int_block) begin
            act   = GXCD_ACT_EXIT;
            cause = GXCD_CAUSE_INT_WIN;
        end else if (i_wr[`GXCD_INSN_NMI_WINDOW] && !vnmi_blk) begin
            act   = GXCD_ACT_EXIT;
            cause = GXCD_CAUSE_NMI_WIN;
        end else begin
            case (lnk.bnd_insn)
                GXCD_INS_HALT: if (i_wr[`GXCD_INSN_HALT_EXIT]) begin
                    act = GXCD_ACT_EXIT;
                    cause = GXCD_CAUSE_HALT;
                end
                GXCD_INS_INVPG: if (i_wr[`GXCD_INSN_INVPG_EXIT]) begin
                    act = GXCD_ACT_EXIT;
                    cause = GXCD_CAUSE_INVPG;
                end
                GXCD_INS_MONITOR_WAIT_INSTRUCTION: if (i_wr[`GXCD_INSN_MONITOR_WAIT_INSTRUCTION_EXIT]) begin
                    act = GXCD_ACT_EXIT;
                    cause = GXCD_CAUSE_MONITOR_WAIT_INSTRUCTION;
                end
                GXCD_INS_PMC: if (i_wr[`GXCD_INSN_PMC_EXIT]) begin
                    act = GXCD_ACT_EXIT;
                    cause = GXCD_CAUSE_PMC;
                end
                GXCD_INS_TSC: if (i_wr[`GXCD_INSN_TSC_EXIT]) begin
                    act = GXCD_ACT_EXIT;
                    cause = GXCD_CAUSE_TSC;
                end else if (i_wr[`GXCD_INSN_TSC_OFFSET]) begin
                    act = GXCD_ACT_TSC_OFFS;
                end
                GXCD_INS_MSR_RD: if (i_wr[`GXCD_INSN_TSC_OFFSET]) begin
                    act = GXCD_ACT_TSC_OFFS;
                end
                GXCD_INS_PRIO_W: if (i_wr[`GXCD_INSN_PRIO_WR_EXIT]) begin
                    act = GXCD_ACT_EXIT;
                    cause = GXCD_CAUSE_PRIO_W;
                end
                GXCD_INS_PRIO_R: if (i_wr[`GXCD_INSN_PRIO_RD_EXIT]) begin
                    act = GXCD_ACT_EXIT;
                    cause = GXCD_CAUSE_PRIO_R;
                end
                GXCD_INS_DBG: if (i_wr[`GXCD_INSN_DBG_EXIT]) begin
                    act = GXCD_ACT_EXIT;
                    cause = GXCD_CAUSE_DBG;
                end
                GXCD_INS_IO: if (i_wr[`GXCD_INSN_IO_BITMAP]) begin
                    act = GXCD_ACT_IO_BMAP;
                end else if (i_wr[`GXCD_INSN_IO_EXIT]) begin
                    act = GXCD_ACT_EXIT;
                    cause = GXCD_CAUSE_IO;
                end
                default: begin
                    act = GXCD_ACT_NORMAL;
                end
            endcase
        end
    end

    // one registered answer per boundary
    always_ff @(posedge lnk.core_clk or negedge lnk.reset_n) begin
        if (!lnk.reset_n) begin
            dec_valid_q  <= 1'b0;
            dec_action_q <= GXCD_ACT_NORMAL;
            dec_cause_q  <= GXCD_CAUSE_NONE;
            ext_masked_q <= 1'b0;
            nmi_blk_q    <= 1'b0;
            vnmi_blk_q   <= 1'b0;
        end else begin
            dec_valid_q  <= lnk.bnd_valid;
            dec_action_q <= lnk.bnd_valid ? act : GXCD_ACT_NORMAL;
            dec_cause_q  <= lnk.bnd_valid ? cause : GXCD_CAUSE_NONE;
            ext_masked_q <= ext_blocked;
            nmi_blk_q    <= nmi_blk;
            vnmi_blk_q   <= vnmi_blk;
        end
    end

    always_ff @(posedge lnk.core_clk or negedge lnk.reset_n) begin
        if (!lnk.reset_n) begin
            exit_count_q <= 32'h0000_0000;
            last_cause_q <= GXCD_CAUSE_NONE;
        end else if (lnk.bnd_valid && act == GXCD_ACT_EXIT) begin
            exit_count_q <= exit_count_q + 32'h0000_0001;
            last_cause_q <= cause;
        end
    end

    assign lnk.dec_valid        = dec_valid_q;
    assign lnk.dec_action       = dec_action_q;
    assign lnk.dec_cause        = dec_cause_q;
    assign lnk.ext_int_masked   = ext_masked_q;
    assign lnk.nmi_blocked      = nmi_blk_q;
    assign lnk.virt_nmi_blocked = vnmi_blk_q;
    assign lnk.tpr_shadow_en    = instruction_exit_controls_q[`GXCD_INSN_TPR_SHADOW];
    assign lnk.entry_fail       = entry_fail_q;
endmodule

// ==== verilog/gxcd_defs.svh ====
// bit positions and reset values for the guest exit control decode block
// assumes inclusion by bare name from package and modules
`ifndef GXCD_DEFS_SVH
`define GXCD_DEFS_SVH

// async event control vector bits
`define GXCD_ASYNC_EXT_INT_EXIT   0
`define GXCD_ASYNC_NMI_EXIT       3
`define GXCD_ASYNC_VIRT_NMI       5
// instruction control vector bits
`define GXCD_INSN_INT_WINDOW      2
`define GXCD_INSN_TSC_OFFSET      3
`define GXCD_INSN_HALT_EXIT       7
`define GXCD_INSN_INVPG_EXIT      9
`define GXCD_INSN_MONITOR_WAIT_INSTRUCTION_EXIT      10
`define GXCD_INSN_PMC_EXIT        11
`define GXCD_INSN_TSC_EXIT        12
`define GXCD_INSN_PRIO_WR_EXIT    19
`define GXCD_INSN_PRIO_RD_EXIT    20
`define GXCD_INSN_TPR_SHADOW      21
`define GXCD_INSN_NMI_WINDOW      22
`define GXCD_INSN_DBG_EXIT        23
`define GXCD_INSN_IO_EXIT         24
`define GXCD_INSN_IO_BITMAP       25
// writable (defined) bits; reserved bits come from the fixed masks
`define GXCD_ASYNC_DEFINED        32'h0000_0029
`define GXCD_INSN_DEFINED         32'h03F8_1E8C
// reserved bits that must read as one (capability values, arbitrary here)
`define GXCD_ASYNC_FIXED1         32'h0000_0016
`define GXCD_INSN_FIXED1          32'h0401_6172
`define GXCD_ASYNC_RESET          32'h0000_0016
`define GXCD_INSN_RESET           32'h0401_6172
// APB register byte offsets
`define GXCD_OFF_ASYNC_CTL        12'h000
`define GXCD_OFF_INSN_CTL         12'h004
`define GXCD_OFF_ASYNC_CAP        12'h008
`define GXCD_OFF_INSN_CAP         12'h00C
`define GXCD_OFF_STATUS           12'h010
`define GXCD_OFF_GUEST            12'h014

`endif

// ==== verilog/gxcd_pkg.sv ====
// types shared by both ends of the guest exit control decode link
// assumes gxcd_defs.svh on the include path
package gxcd_pkg;
    typedef enum logic [3:0] {
        GXCD_INS_NONE   = 4'h0,
        GXCD_INS_HALT   = 4'h1,
        GXCD_INS_INVPG  = 4'h2,
        GXCD_INS_MONITOR_WAIT_INSTRUCTION  = 4'h3,
        GXCD_INS_PMC    = 4'h4,
        GXCD_INS_TSC    = 4'h5,
        GXCD_INS_MSR_RD = 4'h6,
        GXCD_INS_PRIO_W = 4'h7,
        GXCD_INS_PRIO_R = 4'h8,
        GXCD_INS_DBG    = 4'h9,
        GXCD_INS_IO     = 4'hA,
        GXCD_INS_OTHER  = 4'hB
    } gxcd_insn_t;

    typedef enum logic [3:0] {
        GXCD_CAUSE_NONE    = 4'h0,
        GXCD_CAUSE_EXT_INT = 4'h1,
        GXCD_CAUSE_NMI     = 4'h2,
        GXCD_CAUSE_INT_WIN = 4'h3,
        GXCD_CAUSE_NMI_WIN = 4'h4,
        GXCD_CAUSE_HALT    = 4'h5,
        GXCD_CAUSE_INVPG   = 4'h6,
        GXCD_CAUSE_MONITOR_WAIT_INSTRUCTION   = 4'h7,
        GXCD_CAUSE_PMC     = 4'h8,
        GXCD_CAUSE_TSC     = 4'h9,
        GXCD_CAUSE_PRIO_W  = 4'hA,
        GXCD_CAUSE_PRIO_R  = 4'hB,
        GXCD_CAUSE_DBG     = 4'hC,
        GXCD_CAUSE_IO      = 4'hD
    } gxcd_cause_t;

    typedef enum logic [2:0] {
        GXCD_ACT_NORMAL   = 3'h0,
        GXCD_ACT_EXIT     = 3'h1,
        GXCD_ACT_IDT_INT  = 3'h2,
        GXCD_ACT_IDT_NMI  = 3'h3,
        GXCD_ACT_TSC_OFFS = 3'h4,
        GXCD_ACT_IO_BMAP  = 3'h5
    } gxcd_action_t;
endpackage

// ==== verilog/gxcd_if.sv ====
// link between the decode block and the pipeline / event sources
// assumes one shared clock and reset on both ends
`timescale 1ns/1ps
interface gxcd_if (
    input wire logic core_clk,
    input wire logic reset_n
);
    // pipeline offers one instruction boundary per valid cycle
    logic                  bnd_valid;
    gxcd_pkg::gxcd_insn_t  bnd_insn;
    logic                  interrupt_flag;
    logic                  other_int_block;
    logic                  nmi_block_flag;
    logic                  ext_int_pending;
    logic                  nmi_pending;
    // decode answer, one cycle after the boundary
    logic                  dec_valid;
    gxcd_pkg::gxcd_action_t dec_action;
    gxcd_pkg::gxcd_cause_t dec_cause;
    logic                  ext_int_masked;
    logic                  nmi_blocked;
    logic                  virt_nmi_blocked;
    logic                  tpr_shadow_en;
    logic                  entry_fail;

    modport device (
        input  core_clk, reset_n, bnd_valid, bnd_insn, interrupt_flag,
               other_int_block, nmi_block_flag, ext_int_pending, nmi_pending,
        output dec_valid, dec_action, dec_cause, ext_int_masked, nmi_blocked,
               virt_nmi_blocked, tpr_shadow_en, entry_fail
    );
    modport pipe (
        input  core_clk, reset_n, dec_valid, dec_action, dec_cause,
               ext_int_masked, nmi_blocked, virt_nmi_blocked, tpr_shadow_en,
               entry_fail,
        output bnd_valid, bnd_insn, interrupt_flag, other_int_block,
               nmi_block_flag, ext_int_pending, nmi_pending
    );
endinterface

// ==== verilog/gxcd_pipe.sv ====
// pipeline end: presents boundaries and events, takes exit decisions
// assumes the device answers one cycle after each boundary
`timescale 1ns/1ps
module gxcd_pipe (
    // link to decode block
    gxcd_if.pipe                lnk,
    // user side
    input  wire logic           req_valid,
    input  wire gxcd_pkg::gxcd_insn_t req_insn,
    input  wire logic           req_if,
    input  wire logic           req_blk,
    input  wire logic           req_nmi_flag,
    input  wire logic           req_ext_int,
    input  wire logic           req_nmi,
    output logic                req_ready,
    output logic                exit_req,
    output gxcd_pkg::gxcd_cause_t exit_cause,
    output gxcd_pkg::gxcd_action_t done_action,
    output logic                done_valid
);
    import gxcd_pkg::*;

    typedef enum logic [0:0] {
        GXCD_P_IDLE = 1'b0,
        GXCD_P_WAIT = 1'b1
    } gxcd_pst_t;

    gxcd_pst_t    st_q;
    logic         exit_q;
    gxcd_cause_t  cause_q;
    gxcd_action_t act_q;
    logic         done_q;

    assign req_ready = (st_q == GXCD_P_IDLE);

    // one boundary at a time; the decision must come back first
    always_ff @(posedge lnk.core_clk or negedge lnk.reset_n) begin
        if (!lnk.reset_n) begin
            st_q <= GXCD_P_IDLE;
        end else begin
            case (st_q)
                GXCD_P_IDLE: if (req_valid) begin
                    st_q <= GXCD_P_WAIT;
                end
                GXCD_P_WAIT: if (lnk.dec_valid) begin
                    st_q <= GXCD_P_IDLE;
                end
                default: st_q <= GXCD_P_IDLE;
            endcase
        end
    end

    always_ff @(posedge lnk.core_clk or negedge lnk.reset_n) begin
        if (!lnk.reset_n) begin
            exit_q  <= 1'b0;
            cause_q <= GXCD_CAUSE_NONE;
            act_q   <= GXCD_ACT_NORMAL;
            done_q  <= 1'b0;
        end else begin
            done_q  <= lnk.dec_valid;
            exit_q  <= lnk.dec_valid && lnk.dec_action == GXCD_ACT_EXIT;
            cause_q <= lnk.dec_valid ? lnk.dec_cause : GXCD_CAUSE_NONE;
            act_q   <= lnk.dec_valid ? lnk.dec_action : GXCD_ACT_NORMAL;
        end
    end

    assign lnk.bnd_valid       = req_valid && st_q == GXCD_P_IDLE;
    assign lnk.bnd_insn        = req_insn;
    assign lnk.interrupt_flag  = req_if;
    assign lnk.other_int_block = req_blk;
    assign lnk.nmi_block_flag  = req_nmi_flag;
    assign lnk.ext_int_pending = req_ext_int;
    assign lnk.nmi_pending     = req_nmi;
    assign exit_req    = exit_q;
    assign exit_cause  = cause_q;
    assign done_action = act_q;
    assign done_valid  = done_q;
endmodule

// ==== verif/gxcd_monitor.sv ====
// link checker: each decode answer against the boundary that caused it
// assumes instantiation beside the link interface, one clock domain
`timescale 1ns/1ps
module gxcd_monitor (
    // clock and reset
    input wire logic                   core_clk,
    input wire logic                   reset_n,
    // boundary side
    input wire logic                   bnd_valid,
    input wire gxcd_pkg::gxcd_insn_t   bnd_insn,
    input wire logic                   interrupt_flag,
    input wire logic                   other_int_block,
    input wire logic                   nmi_block_flag,
    input wire logic                   ext_int_pending,
    input wire logic                   nmi_pending,
    // decode side
    input wire logic                   dec_valid,
    input wire gxcd_pkg::gxcd_action_t dec_action,
    input wire gxcd_pkg::gxcd_cause_t  dec_cause
);
    import gxcd_pkg::*;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    AST_DEC_FOLLOWS: assert property (bnd_valid |=> dec_valid)
        else $error("boundary without decode answer");
    AST_DEC_CAUSED: assert property (dec_valid |-> $past(bnd_valid))
        else $error("decode answer without boundary");
    AST_SPACING: assert property (bnd_valid |=> !bnd_valid ##1 1'b1)
        else $error("boundaries closer than two cycles");
    AST_EXIT_CAUSE: assert property (dec_valid && dec_action == GXCD_ACT_EXIT
        |-> dec_cause != GXCD_CAUSE_NONE) else $error("exit without cause");
    AST_EXT_SRC: assert property (dec_valid && (dec_cause == GXCD_CAUSE_EXT_INT
        || dec_action == GXCD_ACT_IDT_INT) |-> $past(ext_int_pending))
        else $error("interrupt handled without a pending interrupt");
    AST_NMI_SRC: assert property (dec_valid && (dec_cause == GXCD_CAUSE_NMI
        || dec_action == GXCD_ACT_IDT_NMI) |-> $past(nmi_pending))
        else $error("nmi handled without a pending nmi");
    AST_INT_WIN: assert property (dec_valid && dec_cause == GXCD_CAUSE_INT_WIN
        |-> $past(interrupt_flag) && !$past(other_int_block)) else $error("window shut");
    AST_NMI_WIN: assert property (dec_valid && dec_cause == GXCD_CAUSE_NMI_WIN
        |-> !$past(nmi_block_flag)) else $error("nmi window exit while blocked");
    AST_HALT: assert property (dec_valid && dec_cause == GXCD_CAUSE_HALT
        |-> $past(bnd_insn) == GXCD_INS_HALT) else $error("halt cause on other insn");
    AST_TSC_OFFS: assert property (dec_valid && dec_action == GXCD_ACT_TSC_OFFS
        |-> $past(bnd_insn) inside {GXCD_INS_TSC, GXCD_INS_MSR_RD})
        else $error("offset on a non counter read");
    AST_IO: assert property (dec_valid && (dec_cause == GXCD_CAUSE_IO
        || dec_action == GXCD_ACT_IO_BMAP) |-> $past(bnd_insn) == GXCD_INS_IO)
        else $error("port handling on a non port insn");

    COV_NMI_EXIT: cover property (dec_valid && dec_cause == GXCD_CAUSE_NMI);
    COV_IO_BMAP: cover property (dec_valid && dec_action == GXCD_ACT_IO_BMAP);
    COV_TSC_OFFS: cover property (dec_valid && dec_action == GXCD_ACT_TSC_OFFS);
endmodule

// ==== verif/test_guest_exit_control_decode.sv ====
// bench: pipeline end and decode block joined by the link, apb on the block
// assumes the design files compiled first and gxcd_defs.svh on the include path
`timescale 1ns/1ps
`include "gxcd_defs.svh"
module test_guest_exit_control_decode;
    import gxcd_pkg::*;
    typedef struct packed {
        logic [31:0]  a;
        logic [31:0]  i;
        gxcd_insn_t   ins;
        logic [4:0]   f;
        gxcd_action_t act;
        gxcd_cause_t  cau;
    } gxcd_row_t;
    logic         core_clk = 1'b0;
    logic         reset_n = 1'b0;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [11:0]  paddr = 12'h000;
    logic [31:0]  pwdata = 32'h0;
    logic [31:0]  prdata;
    logic         pready;
    logic         req_valid = 1'b0;
    gxcd_insn_t   req_insn = GXCD_INS_NONE;
    logic [4:0]   req_f = 5'h00;
    logic         req_ready;
    logic         exit_req;
    logic         done_valid;
    gxcd_cause_t  exit_cause;
    gxcd_action_t done_action;
    int           mismatches = 0;
    int           checks = 0;
    int           cycles = 0;
    logic [31:0]  rd;
    // flags are {interrupt_flag, other blocking, nmi flag, ext int, nmi}
    gxcd_row_t    rows [25] = '{
        '{32'h0, 32'h80, GXCD_INS_HALT, 5'h10, GXCD_ACT_EXIT, GXCD_CAUSE_HALT},
        '{32'h0, 32'h200, GXCD_INS_INVPG, 5'h10, GXCD_ACT_EXIT, GXCD_CAUSE_INVPG},
        '{32'h0, 32'h400, GXCD_INS_MONITOR_WAIT_INSTRUCTION, 5'h10, GXCD_ACT_EXIT, GXCD_CAUSE_MONITOR_WAIT_INSTRUCTION},
        '{32'h0, 32'h800, GXCD_INS_PMC, 5'h10, GXCD_ACT_EXIT, GXCD_CAUSE_PMC},
        '{32'h0, 32'h1008, GXCD_INS_TSC, 5'h10, GXCD_ACT_EXIT, GXCD_CAUSE_TSC},
        '{32'h0, 32'h8, GXCD_INS_TSC, 5'h10, GXCD_ACT_TSC_OFFS, GXCD_CAUSE_NONE},
        '{32'h0, 32'h8, GXCD_INS_MSR_RD, 5'h10, GXCD_ACT_TSC_OFFS, GXCD_CAUSE_NONE},
        '{32'h0, 32'h80000, GXCD_INS_PRIO_W, 5'h10, GXCD_ACT_EXIT, GXCD_CAUSE_PRIO_W},
        '{32'h0, 32'h100000, GXCD_INS_PRIO_R, 5'h10, GXCD_ACT_EXIT, GXCD_CAUSE_PRIO_R},
        '{32'h0, 32'h800000, GXCD_INS_DBG, 5'h10, GXCD_ACT_EXIT, GXCD_CAUSE_DBG},
        '{32'h0, 32'h1000000, GXCD_INS_IO, 5'h10, GXCD_ACT_EXIT, GXCD_CAUSE_IO},
        '{32'h0, 32'h3000000, GXCD_INS_IO, 5'h10, GXCD_ACT_IO_BMAP, GXCD_CAUSE_NONE},
        '{32'h0, 32'h200, GXCD_INS_HALT, 5'h10, GXCD_ACT_NORMAL, GXCD_CAUSE_NONE},
        '{32'h1, 32'h0, GXCD_INS_OTHER, 5'h02, GXCD_ACT_EXIT, GXCD_CAUSE_EXT_INT},
        '{32'h0, 32'h0, GXCD_INS_OTHER, 5'h12, GXCD_ACT_IDT_INT, GXCD_CAUSE_NONE},
        '{32'h0, 32'h0, GXCD_INS_OTHER, 5'h02, GXCD_ACT_NORMAL, GXCD_CAUSE_NONE},
        '{32'h8, 32'h0, GXCD_INS_OTHER, 5'h11, GXCD_ACT_EXIT, GXCD_CAUSE_NMI},
        '{32'h0, 32'h0, GXCD_INS_OTHER, 5'h11, GXCD_ACT_IDT_NMI, GXCD_CAUSE_NONE},
        '{32'h28, 32'h0, GXCD_INS_OTHER, 5'h15, GXCD_ACT_EXIT, GXCD_CAUSE_NMI},
        '{32'h0, 32'h0, GXCD_INS_OTHER, 5'h15, GXCD_ACT_NORMAL, GXCD_CAUSE_NONE},
        '{32'h0, 32'h4, GXCD_INS_OTHER, 5'h10, GXCD_ACT_EXIT, GXCD_CAUSE_INT_WIN},
        '{32'h0, 32'h4, GXCD_INS_OTHER, 5'h18, GXCD_ACT_NORMAL, GXCD_CAUSE_NONE},
        '{32'h28, 32'h400000, GXCD_INS_OTHER, 5'h10, GXCD_ACT_EXIT, GXCD_CAUSE_NMI_WIN},
        '{32'h28, 32'h400000, GXCD_INS_OTHER, 5'h14, GXCD_ACT_NORMAL, GXCD_CAUSE_NONE},
        '{32'h9, 32'h0, GXCD_INS_OTHER, 5'h13, GXCD_ACT_EXIT, GXCD_CAUSE_NMI}};

    always #2.5 core_clk = ~core_clk;

    gxcd_if u_gxcd_if (.core_clk(core_clk), .reset_n(reset_n));
    gxcd_device u_gxcd_device (.lnk(u_gxcd_if), .pclk_en_unused(1'b0), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr());
    gxcd_pipe u_gxcd_pipe (.lnk(u_gxcd_if), .req_valid(req_valid), .req_insn(req_insn),
        .req_if(req_f[4]), .req_blk(req_f[3]), .req_nmi_flag(req_f[2]),
        .req_ext_int(req_f[1]), .req_nmi(req_f[0]), .req_ready(req_ready),
        .exit_req(exit_req), .exit_cause(exit_cause), .done_action(done_action),
        .done_valid(done_valid));
    gxcd_monitor u_gxcd_monitor (.core_clk(core_clk), .reset_n(reset_n),
        .bnd_valid(u_gxcd_if.bnd_valid), .bnd_insn(u_gxcd_if.bnd_insn),
        .interrupt_flag(u_gxcd_if.interrupt_flag), .other_int_block(u_gxcd_if.other_int_block),
        .nmi_block_flag(u_gxcd_if.nmi_block_flag), .ext_int_pending(u_gxcd_if.ext_int_pending),
        .nmi_pending(u_gxcd_if.nmi_pending), .dec_valid(u_gxcd_if.dec_valid),
        .dec_action(u_gxcd_if.dec_action), .dec_cause(u_gxcd_if.dec_cause));

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_act(input string n, input gxcd_action_t e, input gxcd_action_t g);
        chk_word(n, {29'h0, e}, {29'h0, g});
    endtask
    task automatic chk_cause(input string n, input gxcd_cause_t e, input gxcd_cause_t g);
        chk_word(n, {28'h0, e}, {28'h0, g});
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        r = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input string n, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk_word(n, e, r);
    endtask
    // reserved ones kept right so only the defined bits decide entry_fail
    task automatic setc(input logic [31:0] a, input logic [31:0] i);
        apb(1'b1, `GXCD_OFF_ASYNC_CTL, a | `GXCD_ASYNC_FIXED1, rd);
        apb(1'b1, `GXCD_OFF_INSN_CTL, i | `GXCD_INSN_FIXED1, rd);
        @(posedge core_clk);
    endtask
    task automatic run(input gxcd_row_t r);
        int n;
        setc(r.a, r.i);
        req_valid <= 1'b1;
        req_insn  <= r.ins;
        req_f     <= r.f;
        do @(posedge core_clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        n = 0;
        while (done_valid !== 1'b1 && n < 20) begin
            @(posedge core_clk);
            n++;
        end
        chk_word("done_valid", 32'h1, {31'h0, done_valid});
        chk_word("exit_req", {31'h0, r.act == GXCD_ACT_EXIT}, {31'h0, exit_req});
        chk_act("action", r.act, done_action);
        chk_cause("cause", r.cau, exit_cause);
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            finish_test();
        end
    end

    initial begin
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        foreach (rows[k]) begin
            run(rows[k]);
        end
        apb(1'b1, `GXCD_OFF_ASYNC_CTL, 32'hFFFFFFFF, rd);
        apb(1'b1, `GXCD_OFF_INSN_CTL, 32'hFFFFFFFF, rd);
        rd_chk("async", `GXCD_OFF_ASYNC_CTL, `GXCD_ASYNC_DEFINED | `GXCD_ASYNC_FIXED1);
        rd_chk("insn", `GXCD_OFF_INSN_CTL, `GXCD_INSN_DEFINED | `GXCD_INSN_FIXED1);
        chk_word("fail_rsvd", 32'h1, {31'h0, u_gxcd_if.entry_fail});
        chk_word("tpr_shadow", 32'h1, {31'h0, u_gxcd_if.tpr_shadow_en});
        apb(1'b1, `GXCD_OFF_ASYNC_CAP, 32'h0, rd);
        rd_chk("async_cap", `GXCD_OFF_ASYNC_CAP, `GXCD_ASYNC_FIXED1);
        rd_chk("insn_cap", `GXCD_OFF_INSN_CAP, `GXCD_INSN_FIXED1);
        rd_chk("unmapped", 12'h020, 32'h0);
        setc(32'h28, 32'h400000);
        chk_word("fail_ok", 32'h0, {31'h0, u_gxcd_if.entry_fail});
        setc(32'h20, 32'h0);
        apb(1'b0, `GXCD_OFF_STATUS, 32'h0, rd);
        chk_word("status_vnmi", 32'h10, rd & 32'h10);
        setc(32'h8, 32'h400000);
        chk_word("fail_win", 32'h1, {31'h0, u_gxcd_if.entry_fail});
        setc(32'h0, 32'h0);
        chk_word("fail_clr", 32'h0, {31'h0, u_gxcd_if.entry_fail});
        chk_word("tpr_off", 32'h0, {31'h0, u_gxcd_if.tpr_shadow_en});
        // second reset in mid-run must restore both vectors
        reset_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        rd_chk("async_rst", `GXCD_OFF_ASYNC_CTL, `GXCD_ASYNC_RESET);
        rd_chk("insn_rst", `GXCD_OFF_INSN_CTL, `GXCD_INSN_RESET);
        run(rows[0]);
        finish_test();
    end
endmodule
